// [psc_motor_model.sv]
// Purpose: polygon motor driver with speed lock output
// Assumes: lock after two reference rising edges while running
// Notes:   fault input forces a speed error
`timescale 1ns/1ps
`default_nettype none
module psc_motor_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic polygon_run_n,
    input  wire logic polygon_ref_clock,
    input  wire logic fault,
    output logic      polygon_lock_n
);
    logic       ref_q;
    logic [2:0] edges_q;
    // spin up on reference edges, stop when run released
    always_ff @(posedge clk or posedge rst) begin
        ref_q <= rst ? 1'b0 : polygon_ref_clock;
        if (rst || polygon_run_n) begin
            edges_q <= 3'h0;
        end else if (polygon_ref_clock && !ref_q && edges_q != 3'h2) begin
            edges_q <= edges_q + 3'h1;
        end
    end
    assign polygon_lock_n = !(edges_q == 3'h2 && !fault);
endmodule
`default_nettype wire

// [psc_pkg.sv]
// Purpose: shared constants for the polygon scanner control block
// Assumes: 10 MHz system clock, link domain on the beam detect side
// Notes:   no software registers; control arrives on plain ports
package psc_pkg;

    // =========================================================
    // clocking and speed
    // =========================================================
    localparam int          CLK_HZ          = 10_000_000;
    localparam int          FACETS          = 6;
    localparam int          RPM_MILLI       = 21_521_147;
    // reference clock edges per facet seen by the motor driver PLL
    localparam int          REF_PER_FACET   = 1;
    // half period of reference clock in system cycles, rounded down
    localparam longint      REF_HZ_MILLI    = longint'(RPM_MILLI) * FACETS * REF_PER_FACET / 60;
    localparam int          REF_HALF_CYC    = int'((longint'(CLK_HZ) * 1000) / (REF_HZ_MILLI * 2));
    localparam int          REF_CNT_W       = 16;

    // =========================================================
    // power loop and facet wrap
    // =========================================================
    localparam int          PWR_W           = 8;
    localparam logic [7:0]  DRIVE_RESET     = 8'h80;
    localparam logic [7:0]  DRIVE_MAX       = 8'hFF;
    localparam logic [7:0]  DRIVE_MIN       = 8'h00;
    localparam logic [2:0]  FACET_LAST      = 3'h5;

endpackage

// [psc_polygon_scanner_control.sv]
// What this block does
// (R1) polygon_run_n driven low runs the motor, high stops it.
// (R2) controller generates polygon_ref_clock for the motor driver PLL.
// (R3) motor stopped while idle, driven at print speed while printing.
// (R4) driver pulls polygon_lock_n low only while locked at speed.
// (R5) laser emission allowed only while lock is indicated.
// (R6) six line scans counted per mirror revolution.
// (R7) horizontal sync derived from the beam detector pulse.
// (R8) monitor level compared with target once per scan line.
// (R9) drive raised when power low, lowered when power high.
// (R10) wrong laser cable connection reports laser_unit_link_error.
// (R11) laser enable drops within four cycles of lock loss.
//
// Purpose: polygon motor, laser gate, sync and power loop control
// Assumes: beam detect pulse sampled in its own link clock domain
// Notes:   comparison result arrives as two level inputs
`timescale 1ns/1ps
`default_nettype none
module psc_polygon_scanner_control (
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire logic                       link_clk,
    input  wire logic                       print_req,
    input  wire logic                       polygon_lock_n,
    input  wire logic                       beam_detect_board,
    input  wire logic                       power_below,
    input  wire logic                       power_above,
    input  wire logic                       laser_cable_ok,
    input  wire logic                       laser_data,
    output logic                            polygon_run_n,
    output logic                            polygon_ref_clock,
    output logic                            laser_enable,
    output logic                            laser_on,
    output logic                            hsync,
    output logic [psc_pkg::PWR_W-1:0]       laser_drive,
    output logic                            auto_laser_power_loop,
    output logic [2:0]                      facet_index,
    output logic                            rev_pulse,
    output logic                            laser_unit_link_error
);
    import psc_pkg::*;

    typedef enum logic [1:0] {
        PSC_IDLE = 2'b00,
        PSC_SPIN = 2'b01,
        PSC_LOCK = 2'b11
    } psc_state_t;

    psc_state_t                     st_q;
    psc_state_t                     st_d;
    logic [REF_CNT_W-1:0]           ref_cnt_q;
    logic                           ref_q;
    logic                           lock_s;
    logic                           cable_s;
    logic                           below_s;
    logic                           above_s;
    logic                           bd_l1_q;
    logic                           bd_l2_q;
    logic                           bd_l3_q;
    logic                           bd_f_q;
    logic                           bd_tog_q;
    logic                           tog_s;
    logic                           tog_prev_q;
    logic [2:0]                     facet_q;
    logic [PWR_W-1:0]               drive_q;
    logic                           hs_q;
    logic                           cmp_q;
    logic                           rev_q;
    logic                           err_q;

    // =========================================================
    // input synchronisers
    // =========================================================
    psc_sync3 #(.RST_VAL(1'b1)) u_lock (
        .clk  (clk),
        .rst  (sys_rst),
        .din  (polygon_lock_n),
        .dout (lock_s)
    );
    psc_sync3 #(.RST_VAL(1'b1)) u_cable (
        .clk  (clk),
        .rst  (sys_rst),
        .din  (laser_cable_ok),
        .dout (cable_s)
    );
    psc_sync3 #(.RST_VAL(1'b0)) u_below (
        .clk  (clk),
        .rst  (sys_rst),
        .din  (power_below),
        .dout (below_s)
    );
    psc_sync3 #(.RST_VAL(1'b0)) u_above (
        .clk  (clk),
        .rst  (sys_rst),
        .din  (power_above),
        .dout (above_s)
    );

    // =========================================================
    // link domain: beam detect edge to toggle
    // =========================================================
    // three stages, a change counts once stages two and three agree
    wire bd_agree = (bd_l2_q == bd_l3_q);
    wire bd_rise  = bd_agree & bd_l3_q & ~bd_f_q;

    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bd_l1_q  <= 1'b0;
            bd_l2_q  <= 1'b0;
            bd_l3_q  <= 1'b0;
            bd_f_q   <= 1'b0;
            bd_tog_q <= 1'b0;
        end else begin
            bd_l1_q <= beam_detect_board;
            bd_l2_q <= bd_l1_q;
            bd_l3_q <= bd_l2_q;
            if (bd_agree) begin
                bd_f_q <= bd_l3_q;
            end
            if (bd_rise) begin
                bd_tog_q <= ~bd_tog_q;   // see (R7)
            end
        end
    end

    psc_sync3 #(.RST_VAL(1'b0)) u_tog (
        .clk  (clk),
        .rst  (sys_rst),
        .din  (bd_tog_q),
        .dout (tog_s)
    );

    // =========================================================
    // motor state
    // =========================================================
    wire locked  = ~lock_s;                               // see (R4)
    wire line_ev = (tog_s != tog_prev_q) & (st_q == PSC_LOCK);
    wire run     = (st_q != PSC_IDLE);

    always_comb begin
        st_d = st_q;
        case (st_q)
            PSC_IDLE: begin
                if (print_req) begin
                    st_d = PSC_SPIN;              // see (R3)
                end
            end
            PSC_SPIN: begin
                if (!print_req) begin
                    st_d = PSC_IDLE;
                end else if (locked) begin
                    st_d = PSC_LOCK;
                end
            end
            PSC_LOCK: begin
                if (!print_req) begin
                    st_d = PSC_IDLE;
                end else if (!locked) begin
                    st_d = PSC_SPIN;
                end
            end
            default: begin
                st_d = PSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= PSC_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // =========================================================
    // reference clock divider
    // =========================================================
    wire ref_wrap = (ref_cnt_q == REF_CNT_W'(REF_HALF_CYC - 1));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ref_cnt_q <= '0;
            ref_q     <= 1'b0;
        end else if (!run) begin
            ref_cnt_q <= '0;
            ref_q     <= 1'b0;                    // see (R3)
        end else if (ref_wrap) begin
            ref_cnt_q <= '0;
            ref_q     <= ~ref_q;                  // see (R2)
        end else begin
            ref_cnt_q <= ref_cnt_q + 1'b1;
        end
    end

    // =========================================================
    // scan line, facet and power loop
    // =========================================================
    wire [PWR_W-1:0] drive_up = (drive_q == DRIVE_MAX) ? drive_q : drive_q + 1'b1;
    wire [PWR_W-1:0] drive_dn = (drive_q == DRIVE_MIN) ? drive_q : drive_q - 1'b1;
    wire [PWR_W-1:0] drive_nx = (below_s && !above_s) ? drive_up :
                                (above_s && !below_s) ? drive_dn : drive_q;   // see (R9)

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tog_prev_q <= 1'b0;
            facet_q    <= 3'h0;
            drive_q    <= DRIVE_RESET;
            hs_q       <= 1'b0;
            cmp_q      <= 1'b0;
            rev_q      <= 1'b0;
            err_q      <= 1'b0;
        end else begin
            tog_prev_q <= tog_s;
            hs_q       <= line_ev;                // see (R7)
            cmp_q      <= line_ev;                // see (R8)
            rev_q      <= line_ev & (facet_q == FACET_LAST);
            err_q      <= ~cable_s;               // see (R10)
            if (line_ev) begin
                facet_q <= (facet_q == FACET_LAST) ? 3'h0 : facet_q + 1'b1;   // see (R6)
                drive_q <= drive_nx;              // see (R8)
            end
        end
    end

    // =========================================================
    // outputs
    // =========================================================
    wire gate = locked & (st_q == PSC_LOCK) & ~err_q;    // see (R5)

    assign polygon_run_n         = ~run;                 // see (R1)
    assign polygon_ref_clock     = ref_q;
    assign laser_enable          = gate;                 // see (R11)
    assign laser_on              = gate & laser_data;    // see (R5)
    assign hsync                 = hs_q;
    assign laser_drive           = drive_q;
    assign auto_laser_power_loop = cmp_q;
    assign facet_index           = facet_q;
    assign rev_pulse             = rev_q;
    assign laser_unit_link_error = err_q;
endmodule
`default_nettype wire

// [psc_polygon_scanner_control_chk.sv]
// Purpose: port assertions for the scanner control block
// Assumes: power and cable inputs held steady around a scan
// Notes:   bound into the top module
`timescale 1ns/1ps
`default_nettype none
module psc_polygon_scanner_control_chk (
    input wire logic                  clk,
    input wire logic                  sys_rst,
    input wire logic                  print_req,
    input wire logic                  polygon_lock_n,
    input wire logic                  power_below,
    input wire logic                  power_above,
    input wire logic                  laser_cable_ok,
    input wire logic                  laser_data,
    input wire logic                  polygon_run_n,
    input wire logic                  polygon_ref_clock,
    input wire logic                  laser_enable,
    input wire logic                  laser_on,
    input wire logic                  hsync,
    input wire logic [psc_pkg::PWR_W-1:0] laser_drive,
    input wire logic                  auto_laser_power_loop,
    input wire logic [2:0]            facet_index,
    input wire logic                  rev_pulse,
    input wire logic                  laser_unit_link_error
);
    import psc_pkg::*;
    logic [15:0] ref_gap_q;
    // cycles since the reference clock last moved while running
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ref_gap_q <= 16'h0000;
        end else if (polygon_run_n || $changed(polygon_ref_clock)) begin
            ref_gap_q <= 16'h0000;
        end else begin
            ref_gap_q <= ref_gap_q + 16'h0001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_low;
        (power_below && !power_above) [*8];
    endsequence
    sequence s_high;
        (power_above && !power_below) [*8];
    endsequence
    chk_run_follow: assert property ($stable(print_req) |=> polygon_run_n == !$past(print_req))
        else $error("run output wrong");
    chk_ref_idle: assert property (polygon_run_n [*3] |-> !polygon_ref_clock)
        else $error("ref clock not idle");
    chk_ref_runs: assert property (!polygon_run_n |-> ref_gap_q < 16'(REF_HALF_CYC + 1))
        else $error("ref clock stuck");
    chk_gate_lock: assert property (polygon_lock_n [*7] |-> !laser_enable && !hsync)
        else $error("laser on without lock");
    chk_gate_mode: assert property (laser_enable |-> !polygon_run_n && !laser_unit_link_error)
        else $error("laser on while stopped");
    chk_laser_and: assert property (laser_on == (laser_enable && laser_data))
        else $error("laser output wrong");
    chk_sync_pair: assert property ((hsync || auto_laser_power_loop)
        |-> (hsync && auto_laser_power_loop) ##1 !hsync) else $error("sync pulse wrong");
    chk_drive_hold: assert property (!hsync |-> $stable(laser_drive))
        else $error("drive moved off scan");
    chk_drive_up: assert property (s_low ##0 (hsync && $past(laser_drive) != DRIVE_MAX)
        |-> laser_drive == $past(laser_drive) + 8'h01) else $error("drive not raised");
    chk_drive_down: assert property (s_high ##0 (hsync && $past(laser_drive) != DRIVE_MIN)
        |-> laser_drive == $past(laser_drive) - 8'h01) else $error("drive not lowered");
    chk_facet_wrap: assert property (rev_pulse |-> facet_index == 3'h0 && $past(facet_index) == FACET_LAST)
        else $error("facet wrap wrong");
    chk_link_err: assert property ($stable(laser_cable_ok) [*7] |-> laser_unit_link_error == !laser_cable_ok)
        else $error("cable error wrong");
endmodule
bind psc_polygon_scanner_control psc_polygon_scanner_control_chk u_chk (.clk, .sys_rst, .print_req,
    .polygon_lock_n, .power_below, .power_above, .laser_cable_ok, .laser_data, .polygon_run_n,
    .polygon_ref_clock, .laser_enable, .laser_on, .hsync, .laser_drive, .auto_laser_power_loop,
    .facet_index, .rev_pulse, .laser_unit_link_error);
`default_nettype wire

// [psc_polygon_scanner_control_tb.sv]
// Purpose: self-checking bench for scanner control
// Assumes: bench stands in for the beam detect board
// Notes:   scan results checked from a queue of notes
`timescale 1ns/1ps
`default_nettype none
module psc_polygon_scanner_control_tb;
    import psc_pkg::*;
    logic        clk, sys_rst, link_clk, print_req, beam_detect_board, fault;
    logic        power_below, power_above, laser_cable_ok, laser_data;
    logic        polygon_run_n, polygon_ref_clock, laser_enable, laser_on, hsync;
    logic        auto_laser_power_loop, rev_pulse, laser_unit_link_error, polygon_lock_n;
    logic [7:0]  laser_drive, drv;
    logic [2:0]  facet_index, fct;
    logic [1:0]  pw;
    logic [15:0] exp_q[$];
    int          miscompares, total_checks, i;
    wire [15:0]  scan_seen = {3'h0, auto_laser_power_loop, rev_pulse, facet_index, laser_drive};
    psc_polygon_scanner_control DUT (.clk, .sys_rst, .link_clk, .print_req, .polygon_lock_n,
        .beam_detect_board, .power_below, .power_above, .laser_cable_ok, .laser_data, .polygon_run_n,
        .polygon_ref_clock, .laser_enable, .laser_on, .hsync, .laser_drive, .auto_laser_power_loop,
        .facet_index, .rev_pulse, .laser_unit_link_error);
    psc_motor_model u_motor (.clk, .rst(sys_rst), .polygon_run_n, .polygon_ref_clock, .fault, .polygon_lock_n);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wait_enable(input logic val);
        for (int n = 0; n < 10000 && laser_enable !== val; n++) @(posedge clk);
        check({15'h0, laser_enable}, {15'h0, val});
    endtask
    task automatic beam(input logic [1:0] p);
        @(posedge clk);
        power_below <= p[0];
        power_above <= p[1];
        laser_data <= 1'($urandom);
        repeat (10) @(posedge clk);
        @(posedge link_clk) beam_detect_board <= 1'b1;
        repeat (3) @(posedge link_clk);
        beam_detect_board <= 1'b0;
        repeat (12) @(posedge clk);
    endtask
    // ==========================================
    // clocks, watcher and watchdog
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #17;
        forever #40 link_clk = ~link_clk;
    end
    always @(posedge clk) begin
        if (hsync === 1'b1) begin
            if (exp_q.size() == 0) check(16'hFFFF, 16'h0000);
            else check(scan_seen, exp_q.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        complete_run;
    end
    // ==========================================
    // tests
    initial begin
        {sys_rst, laser_cable_ok} = 2'h3;
        {print_req, beam_detect_board, fault, power_below, power_above, laser_data} = 6'h00;
        void'($urandom(32'h6C036044));
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk);
        check({7'h0, polygon_run_n, laser_drive}, {8'h01, DRIVE_RESET});
        $display("test reset done");
        print_req <= 1'b1;
        wait_enable(1'b1);
        check({15'h0, polygon_run_n}, 16'h0000);
        $display("test spin done");
        drv = DRIVE_RESET;
        fct = 3'h0;
        for (i = 0; i < 14; i++) begin
            pw = 2'($urandom);
            drv = (pw == 2'h1) ? drv + 8'h01 : (pw == 2'h2) ? drv - 8'h01 : drv;
            fct = (fct == FACET_LAST) ? 3'h0 : fct + 3'h1;
            exp_q.push_back({3'h0, 1'b1, fct == 3'h0, fct, drv});
            beam(pw);
            check({15'h0, laser_on}, {15'h0, laser_data});
        end
        check(16'(exp_q.size()), 16'h0000);
        $display("test scan done");
        fault <= 1'b1;
        wait_enable(1'b0);
        beam(2'h1);
        fault <= 1'b0;
        wait_enable(1'b1);
        $display("test lock loss done");
        laser_cable_ok <= 1'b0;
        repeat (8) @(posedge clk);
        check({14'h0, laser_unit_link_error, laser_enable}, 16'h0002);
        laser_cable_ok <= 1'b1;
        wait_enable(1'b1);
        $display("test cable done");
        print_req <= 1'b0;
        repeat (6) @(posedge clk);
        check({14'h0, polygon_run_n, polygon_ref_clock}, 16'h0002);
        $display("test stop done");
        complete_run;
    end
endmodule
`default_nettype wire

// [psc_sync3.sv]
// Purpose: three stage synchroniser with agreement filter
// Assumes: input asynchronous to clk
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module psc_sync3 #(
    parameter logic         RST_VAL = 1'b0
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       din,
    output logic            dout
);
    logic                   s1_q;
    logic                   s2_q;
    logic                   s3_q;
    wire                    agree = (s2_q == s3_q);

    // =========================================================
    // stages and filtered output
    // =========================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (agree) begin
                dout <= s3_q;
            end
        end
    end
endmodule
`default_nettype wire
